/* File: core/boost_led_sequencer.sv */
/*
 * enable, soft start, protection and dimming reference sequencer of a
 * single channel boost led driver. assumes analog comparators supply
 * the flags, an on-chip sensor supplies the junction temperature code
 * in this clock domain, and the analog loop consumes the limit, target
 * and gate outputs.
 */
`default_nettype none

// Function
// - switch on until peak current, then off for a fixed off-time
// - after enable, soft start with the reduced start-up current limit
// - after 6.5 ms restore normal limit, then ramp reference slowly up
// - open led: overvoltage with feedback below 30 mV for 3 cycles shuts down
// - after open led shutdown stay off until ctrl is toggled
// - shut down only after ctrl low continuously more than 2.5 ms
// - in shutdown the switch never switches and low power mode is set
// - ctrl held high regulates feedback to the full 204 mV reference
// - reference chopped by pwm, low-pass filtered, used as feedback target
// - supply undervoltage shuts down with switch off, restarts when cleared
// - above 100 C the current limit falls as temperature rises
// - above 160 C shut down, release after cooling by 15 C
// - activate when supply is good and ctrl is high, starting soft start
module boost_led_sequencer
    import led_seq_pkg::*;
#(
    parameter logic [CNT_W-1:0] LOW_SHUTDOWN_CYCLES = CNT_W'(LOW_SHUTDOWN_CYC),
    parameter logic [CNT_W-1:0] SOFT_START_CYCLES   = CNT_W'(SOFT_START_CYC),
    parameter logic [CNT_W-1:0] RAMP_STEP_CYCLES    = CNT_W'(RAMP_STEP_CYC),
    parameter logic [7:0]       OFF_CYCLES          = 8'(OFF_TIME_CYC)
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    srst,
    // analog comparators and temperature
    input  wire led_seq_pkg::compFlags_s compFlags,
    input  wire logic [7:0]              junctionTempC,
    // power stage control
    output logic                         switchGate,
    output logic [11:0]                  switchCurrentLimitMa,
    output logic [7:0]                   feedbackTargetMv,
    // status
    output logic                         softStartActive,
    output logic                         lowPowerMode,
    output logic                         openLedFault,
    output logic                         thermalShutdown
);
    import led_seq_pkg::*;

    // ==================================================================
    // input synchronisation
    compFlags_s flags;

    flag_sync #(.WIDTH($bits(compFlags_s))) uFlagSync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .asyncIn (compFlags),
        .syncOut (flags)
    );

    // ==================================================================
    // ctrl low timer and thermal hysteresis
    logic [CNT_W-1:0] lowCnt;
    logic [CNT_W-1:0] next_lowCnt;
    logic             next_thermalShutdown;
    logic             lowShutdown;

    always_comb begin
        next_lowCnt = '0;
        if (!flags.ctrl) begin
            next_lowCnt = (lowCnt > LOW_SHUTDOWN_CYCLES) ? lowCnt : lowCnt + 1'b1;
        end
        next_thermalShutdown = thermalShutdown;
        if (junctionTempC > HOT_TRIP_C) begin
            next_thermalShutdown = 1'b1;
        end else if (junctionTempC <= HOT_RELEASE_C) begin
            next_thermalShutdown = 1'b0;
        end
    end

    // strictly more than the low time, so a pulse of exactly that length dims
    assign lowShutdown = (lowCnt > LOW_SHUTDOWN_CYCLES);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lowCnt          <= '0;
            thermalShutdown <= 1'b0;
        end else begin
            lowCnt          <= next_lowCnt;
            thermalShutdown <= next_thermalShutdown;
        end
    end

    // ==================================================================
    // sequencer state machine
    seqState_e        state;
    seqState_e        next_state;
    logic [CNT_W-1:0] ssCnt;
    logic [CNT_W-1:0] next_ssCnt;
    logic             sawLow;
    logic             next_sawLow;
    logic             active;
    logic             stopReq;
    logic             startOk;
    logic             openLedTrip;

    assign active  = (state == ST_SOFT) || (state == ST_RUN);
    assign stopReq = lowShutdown || flags.supply_undervoltage_lockout || thermalShutdown;
    assign startOk = flags.ctrl && !flags.supply_undervoltage_lockout && !thermalShutdown;

    always_comb begin
        next_state  = state;
        next_ssCnt  = '0;
        next_sawLow = 1'b0;
        unique case (state)
            ST_OFF: begin
                if (startOk) begin
                    next_state = ST_SOFT;
                end
            end
            ST_SOFT, ST_RUN: begin
                if (state == ST_SOFT) begin
                    next_ssCnt = ssCnt + 1'b1;
                end
                if (stopReq) begin
                    next_state = ST_OFF;
                end else if (openLedTrip) begin
                    next_state = ST_FAULT;
                end else if (state == ST_SOFT && ssCnt == SOFT_START_CYCLES - 1'b1) begin
                    next_state = ST_RUN;
                end
            end
            ST_FAULT: begin
                // only a low then high on ctrl rearms the driver
                next_sawLow = sawLow || !flags.ctrl;
                if (sawLow && startOk) begin
                    next_state = ST_SOFT;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state  <= ST_OFF;
            ssCnt  <= '0;
            sawLow <= 1'b0;
        end else begin
            state  <= next_state;
            ssCnt  <= next_ssCnt;
            sawLow <= next_sawLow;
        end
    end

    // ==================================================================
    // switching cycle and open led detection
    logic       offPhase;
    logic       next_offPhase;
    logic [7:0] offCnt;
    logic [7:0] next_offCnt;
    logic [1:0] ovpCnt;
    logic [1:0] next_ovpCnt;
    logic       next_switchGate;
    logic       cycleTick;

    // the peak flag carries sync latency; the off-time absorbs it
    assign cycleTick   = offPhase && (offCnt == 8'h01);
    assign openLedTrip = cycleTick && flags.overvoltage && flags.fbLow
                         && (ovpCnt == OPEN_LED_CYCLES - 2'h1);

    always_comb begin
        next_offPhase   = offPhase;
        next_offCnt     = offCnt;
        next_switchGate = switchGate;
        next_ovpCnt     = ovpCnt;
        if (!active || stopReq || openLedTrip) begin
            next_offPhase   = 1'b0;
            next_offCnt     = '0;
            next_switchGate = 1'b0;
            next_ovpCnt     = '0;
        end else if (!offPhase) begin
            next_switchGate = 1'b1;
            if (switchGate && flags.peak) begin
                next_switchGate = 1'b0;
                next_offPhase   = 1'b1;
                next_offCnt     = OFF_CYCLES;
            end
        end else begin
            next_offCnt = offCnt - 8'h01;
            if (cycleTick) begin
                next_offPhase   = 1'b0;
                next_switchGate = 1'b1;
                next_ovpCnt     = (flags.overvoltage && flags.fbLow) ? ovpCnt + 2'h1
                                                                     : 2'h0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            offPhase   <= 1'b0;
            offCnt     <= '0;
            ovpCnt     <= '0;
            switchGate <= 1'b0;
        end else begin
            offPhase   <= next_offPhase;
            offCnt     <= next_offCnt;
            ovpCnt     <= next_ovpCnt;
            switchGate <= next_switchGate;
        end
    end

    // ==================================================================
    // dimming reference: chop, low-pass, slow ramp after soft start
    logic [7:0]           chopRef;
    logic [REF_ACC_W-1:0] refAcc;
    logic [REF_ACC_W-1:0] next_refAcc;
    logic [7:0]           refFilt;
    logic [7:0]           ramp;
    logic [7:0]           next_ramp;
    logic [CNT_W-1:0]     rampCnt;
    logic [CNT_W-1:0]     next_rampCnt;
    logic [7:0]           next_feedbackTargetMv;

    assign chopRef = (active && flags.ctrl) ? REF_FULL_MV : 8'h00;
    assign refFilt = refAcc[REF_ACC_W-1:REF_FILT_SHIFT];

    always_comb begin
        // first order filter, settles exactly to the chopped mean
        next_refAcc  = refAcc + REF_ACC_W'(chopRef) - REF_ACC_W'(refFilt);
        next_ramp    = ramp;
        next_rampCnt = rampCnt;
        if (state != ST_RUN) begin
            next_ramp    = '0;
            next_rampCnt = '0;
        end else if (ramp != REF_FULL_MV) begin
            next_rampCnt = rampCnt + 1'b1;
            if (rampCnt == RAMP_STEP_CYCLES - 1'b1) begin
                next_rampCnt = '0;
                next_ramp    = ramp + 8'h01;
            end
        end
        next_feedbackTargetMv = (refFilt < ramp) ? refFilt : ramp;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            refAcc           <= '0;
            ramp             <= '0;
            rampCnt          <= '0;
            feedbackTargetMv <= '0;
        end else begin
            refAcc           <= next_refAcc;
            ramp             <= next_ramp;
            rampCnt          <= next_rampCnt;
            feedbackTargetMv <= next_feedbackTargetMv;
        end
    end

    // ==================================================================
    // current limit, status outputs
    logic [11:0] foldDrop;
    logic [11:0] next_limit;

    always_comb begin
        foldDrop = '0;
        if (junctionTempC > FOLD_START_C) begin
            foldDrop = 12'(junctionTempC - FOLD_START_C) * FOLD_STEP_MA;
        end
        if (state == ST_SOFT) begin
            next_limit = LIMIT_START_MA;
        end else if (foldDrop >= LIMIT_NORMAL_MA - LIMIT_START_MA) begin
            next_limit = LIMIT_START_MA;
        end else begin
            next_limit = LIMIT_NORMAL_MA - foldDrop;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            switchCurrentLimitMa <= LIMIT_START_MA;
            softStartActive      <= 1'b0;
            lowPowerMode         <= 1'b1;
            openLedFault         <= 1'b0;
        end else begin
            switchCurrentLimitMa <= next_limit;
            softStartActive      <= (next_state == ST_SOFT);
            lowPowerMode         <= !((next_state == ST_SOFT) || (next_state == ST_RUN));
            openLedFault         <= (next_state == ST_FAULT);
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence ovpTick_s;
        cycleTick && flags.overvoltage && flags.fbLow;
    endsequence

    idle_gate_off_a: assert property (!active |=> !switchGate)
        else $error("switch gate high while shut down");
    peak_ends_on_a: assert property (switchGate && !offPhase && flags.peak |=> !switchGate)
        else $error("switch stayed on past peak");
    off_time_a: assert property ($fell(switchGate) && active |-> offCnt == OFF_CYCLES)
        else $error("off-time not loaded");
    open_led_a: assert property ((ovpCnt == 2'h2 && !stopReq) and ovpTick_s
        |=> state == ST_FAULT)
        else $error("open led not latched on third cycle");
    fault_hold_a: assert property (state == ST_FAULT && !sawLow |=> state == ST_FAULT)
        else $error("fault left without ctrl toggle");
    low_shutdown_a: assert property (active && lowShutdown
        |=> state == ST_OFF && lowPowerMode)
        else $error("no shutdown after long ctrl low");
    start_limit_a: assert property (state == ST_SOFT |=> switchCurrentLimitMa == LIMIT_START_MA)
        else $error("start-up limit not applied");
    soft_end_a: assert property (state == ST_SOFT && !stopReq && !openLedTrip
        && ssCnt == SOFT_START_CYCLES - 1'b1 |=> state == ST_RUN ##1 ramp == 8'h00)
        else $error("soft start did not end on time");
    full_ref_a: assert property (active && flags.ctrl |=> refFilt >= $past(refFilt))
        else $error("filtered reference fell while ctrl held high");
    supply_undervoltage_lockout_stop_a: assert property (active && flags.supply_undervoltage_lockout |=> state == ST_OFF ##1 !switchGate)
        else $error("undervoltage did not shut down");
    foldback_a: assert property (state == ST_RUN && junctionTempC > FOLD_START_C
        |=> switchCurrentLimitMa < LIMIT_NORMAL_MA)
        else $error("no foldback above 100 C");
    hot_hold_a: assert property (thermalShutdown && junctionTempC > HOT_RELEASE_C
        |=> thermalShutdown)
        else $error("thermal shutdown released too early");
    enable_a: assert property (state == ST_OFF && startOk |=> state == ST_SOFT)
        else $error("enable did not start soft start");

endmodule // boost_led_sequencer

`default_nettype wire

/* File: core/led_seq_pkg.sv */
/*
 * constants and carriers shared by the boost led sequencer and its
 * self-checking bench. assumes a single 125 MHz system clock.
 */
`default_nettype none

package led_seq_pkg;

    // ==================================================================
    // clock and timing
    localparam int CLK_MHZ          = 125;
    localparam int CNT_W            = 20;
    localparam int LOW_SHUTDOWN_US  = 2500;  // ctrl low time to shutdown
    localparam int SOFT_START_US    = 6500;  // reduced limit interval
    localparam int RAMP_STEP_NS     = 5000;  // reference ramp step period
    localparam int OFF_TIME_NS      = 200;   // fixed switch off-time
    localparam int SW_FREQ_KHZ      = 1200;  // nominal switching rate
    // least times round up
    localparam int LOW_SHUTDOWN_CYC = LOW_SHUTDOWN_US * CLK_MHZ;
    localparam int SOFT_START_CYC   = SOFT_START_US * CLK_MHZ;
    localparam int RAMP_STEP_CYC    = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int OFF_TIME_CYC     = (OFF_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int SW_PERIOD_CYC    = (CLK_MHZ * 1000) / SW_FREQ_KHZ;

    // ==================================================================
    // protection thresholds
    localparam logic [1:0]  OPEN_LED_CYCLES = 2'h3;
    localparam logic [7:0]  FOLD_START_C    = 8'h64;  // 100 C
    localparam logic [7:0]  HOT_TRIP_C      = 8'hA0;  // 160 C
    localparam logic [7:0]  HOT_HYST_C      = 8'h0F;  // 15 C
    localparam logic [7:0]  HOT_RELEASE_C   = HOT_TRIP_C - HOT_HYST_C;

    // ==================================================================
    // current limit and reference, in mA and mV
    localparam logic [11:0] LIMIT_NORMAL_MA = 12'h708;  // 1800
    localparam logic [11:0] LIMIT_START_MA  = 12'h2D0;  // 720
    localparam logic [11:0] FOLD_STEP_MA    = 12'h00A;  // per degree
    localparam logic [7:0]  REF_FULL_MV     = 8'hCC;    // 204
    localparam int          REF_FILT_SHIFT  = 17;       // about 1 ms at 125 MHz
    localparam int          REF_ACC_W       = 8 + REF_FILT_SHIFT;

    // ==================================================================
    // sequencer states
    typedef enum logic [3:0] {
        ST_OFF   = 4'b0001,
        ST_SOFT  = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_FAULT = 4'b1000
    } seqState_e;

    // comparator flags from the analog side, all asynchronous
    typedef struct packed {
        logic ctrl;        // pwm dimming / enable pin above 1.2 V
        logic peak;        // inductor current reached the amplifier level
        logic overvoltage; // switch_node above overvoltage_threshold
        logic fbLow;       // feedback_sense below 30 mV
        logic supply_undervoltage_lockout;        // supply_undervoltage_lockout, hysteresis in comparator
    } compFlags_s;

endpackage

`default_nettype wire

/* File: core/flag_sync.sv */
/*
 * three stage synchroniser for a vector of asynchronous flags.
 * assumes each bit is independent; a change is taken only once the
 * second and third stages agree, which also rejects single-edge glitches.
 */
`default_nettype none

module flag_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // flags
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    // ==================================================================
    // stages
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_syncOut;

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_syncOut[i] = (stage2[i] == stage3[i]) ? stage3[i] : syncOut[i];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stage1  <= '0;
            stage2  <= '0;
            stage3  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= asyncIn;
            stage2  <= stage1;
            stage3  <= stage2;
            syncOut <= next_syncOut;
        end
    end

endmodule // flag_sync

`default_nettype wire

/* File: tb/host_pwm_model.sv */
/*
 * host side of the dimming/enable pin: a steady level or a pwm train.
 * assumes the bench scales the pwm period so a low phase stays under
 * the shortened shutdown count.
 */
`default_nettype none

module host_pwm_model (
    // clock
    input  wire logic        clk_sys,
    // control from the bench
    input  wire logic        pwmOn,
    input  wire logic        level,
    input  wire logic [15:0] periodCyc,
    input  wire logic [15:0] highCyc,
    // pin
    output var logic         ctrl = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] phase = 16'h0000;

    // ==================================================================
    // pwm generation
    // the real host runs 5 to 100 kHz; the period here is scaled down
    // with the shutdown count, trading realism for run time
    always @(negedge clk_sys) begin
        phase <= (phase + 16'h0001 >= periodCyc) ? 16'h0000 : phase + 16'h0001;
        ctrl  <= pwmOn ? (phase < highCyc) : level;
    end
endmodule // host_pwm_model

`default_nettype wire

/* File: tb/boost_led_sequencer_tb_top.sv */
/*
 * self-checking bench of the boost led sequencer.
 * assumes shortened counts set below and a crude power stage that
 * reports peak current two cycles after the switch turns on.
 */
`default_nettype none

module boost_led_sequencer_tb_top
    import led_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    compFlags_s flagsTb = '0;
    compFlags_s compFlags;
    logic peakPin = 1'b0;
    logic ctrlPin;
    logic pwmOn = 1'b0;
    logic level = 1'b0;
    logic [7:0] temp = 8'h19;
    logic [7:0] onCnt = 8'h00;
    logic switchGate, softStartActive, lowPowerMode, openLedFault, thermalShutdown;
    logic [11:0] limitMa;
    logic [7:0] targetMv, tA, tB;
    int n_fail = 0;
    int n_checks = 0;
    int n;

    // ==================================================================
    // clock, partner and power stage
    initial forever #4 clk_sys = ~clk_sys;

    host_pwm_model host (.clk_sys(clk_sys), .pwmOn(pwmOn), .level(level),
        .periodCyc(16'h0028), .highCyc(16'h0014), .ctrl(ctrlPin));

    // peak only follows an on switch, so a stopped switch ends all cycles
    always @(negedge clk_sys) begin
        onCnt   <= switchGate ? onCnt + 8'h01 : 8'h00;
        peakPin <= switchGate && (onCnt >= 8'h02);
    end

    always_comb begin
        compFlags      = flagsTb;
        compFlags.ctrl = ctrlPin;
        compFlags.peak = peakPin;
    end

    boost_led_sequencer #(
        .LOW_SHUTDOWN_CYCLES(CNT_W'(40)),
        .SOFT_START_CYCLES  (CNT_W'(60)),
        .RAMP_STEP_CYCLES   (CNT_W'(2)),
        .OFF_CYCLES         (8'(4))
    ) DUT (
        .clk_sys             (clk_sys),
        .srst                (srst),
        .compFlags           (compFlags),
        .junctionTempC       (temp),
        .switchGate          (switchGate),
        .switchCurrentLimitMa(limitMa),
        .feedbackTargetMv    (targetMv),
        .softStartActive     (softStartActive),
        .lowPowerMode        (lowPowerMode),
        .openLedFault        (openLedFault),
        .thermalShutdown     (thermalShutdown)
    );

    // ==================================================================
    // tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic step(input int c);
        repeat (c) @(negedge clk_sys);
    endtask

    task automatic doReset();
        srst = 1'b1;
        step(4);
        srst = 1'b0;
    endtask

    // state change lands within sync depth plus one edge; 8 leaves margin
    task automatic settle();
        step(8);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end

    // ==================================================================
    // tests
    initial begin
        doReset();
        check(switchGate, 16'h0);
        check(lowPowerMode, 16'h1);
        check(limitMa, 16'h02D0);
        check(targetMv, 16'h0);
        level = 1'b1;
        settle();
        check(softStartActive, 16'h1);
        check(lowPowerMode, 16'h0);
        check(limitMa, 16'h02D0);
        step(70);
        check(softStartActive, 16'h0);
        check(limitMa, 16'h0708);
        step(19900);
        tA = targetMv;
        check(tA > 8'd20 && tA < 8'd40, 16'h1);
        // off-time from the first falling switch edge to the next rise
        n = 0;
        while (switchGate !== 1'b1 && n < 100) begin n++; step(1); end
        while (switchGate !== 1'b0 && n < 200) begin n++; step(1); end
        n = 0;
        while (switchGate === 1'b0 && n < 100) begin n++; step(1); end
        check(16'(n), 16'h4);
        temp = 8'd120;
        settle();
        check(limitMa, 16'h0640);
        temp = 8'd170;
        settle();
        check(thermalShutdown, 16'h1);
        check(lowPowerMode, 16'h1);
        check(switchGate, 16'h0);
        temp = 8'd150;
        settle();
        check(thermalShutdown, 16'h1);
        temp = 8'd145;
        settle();
        check(thermalShutdown, 16'h0);
        check(softStartActive, 16'h1);
        temp = 8'd25;
        step(70);
        level = 1'b0;
        step(34);
        level = 1'b1;
        settle();
        check(lowPowerMode, 16'h0);
        level = 1'b0;
        step(60);
        check(lowPowerMode, 16'h1);
        n = 0;
        repeat (50) begin step(1); n += int'(switchGate === 1'b1); end
        check(16'(n), 16'h0);
        level = 1'b1;
        step(80);
        flagsTb.overvoltage = 1'b1;
        step(100);
        check(openLedFault, 16'h0);
        flagsTb.fbLow = 1'b1;
        step(60);
        check(openLedFault, 16'h1);
        check(switchGate, 16'h0);
        check(lowPowerMode, 16'h1);
        flagsTb.overvoltage = 1'b0;
        flagsTb.fbLow = 1'b0;
        step(100);
        check(openLedFault, 16'h1);
        level = 1'b0;
        step(10);
        level = 1'b1;
        settle();
        check(openLedFault, 16'h0);
        check(softStartActive, 16'h1);
        step(80);
        flagsTb.supply_undervoltage_lockout = 1'b1;
        settle();
        check(lowPowerMode, 16'h1);
        check(switchGate, 16'h0);
        flagsTb.supply_undervoltage_lockout = 1'b0;
        settle();
        check(softStartActive, 16'h1);
        // second start at half duty: target about half of the steady one
        doReset();
        pwmOn = 1'b1;
        step(19978);
        tB = targetMv;
        check(lowPowerMode, 16'h0);
        check(tB > 8'd0 && tB < tA, 16'h1);
        check(({1'b0, tB} << 1) + 9'd8 > {1'b0, tA} && ({1'b0, tB} << 1) < {1'b0, tA} + 9'd8,
              16'h1);
        summarize();
    end
endmodule // boost_led_sequencer_tb_top

`default_nettype wire
